// file: core/mfl_pkg.sv
package mfl_pkg;
   // -------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------
   localparam int PORTS_DEF = 10;
   localparam int GRP_N_DEF = 8;
   localparam int RTR_N_DEF = 4;
   localparam int VID_W     = 12;
   localparam int GADDR_W   = 32;
   localparam int LIFE_W    = 16;
   localparam int DIP_W     = 128;
   localparam int MAC_W     = 48;
   localparam int DATA_W    = 32;
   localparam int DEC_W     = 8;

   // -------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------
   localparam logic [DEC_W-1:0] ADDR_CTRL       = 8'h00;
   localparam logic [DEC_W-1:0] ADDR_AGE        = 8'h04;
   localparam logic [DEC_W-1:0] ADDR_GRP_SEL    = 8'h10;
   localparam logic [DEC_W-1:0] ADDR_GRP_KEY    = 8'h14;
   localparam logic [DEC_W-1:0] ADDR_GRP_ADDR   = 8'h18;
   localparam logic [DEC_W-1:0] ADDR_GRP_MEMBER = 8'h1C;
   localparam logic [DEC_W-1:0] ADDR_GRP_LIFE   = 8'h20;
   localparam logic [DEC_W-1:0] ADDR_RTR_SEL    = 8'h30;
   localparam logic [DEC_W-1:0] ADDR_RTR_KEY    = 8'h34;
   localparam logic [DEC_W-1:0] ADDR_RTR_STATIC = 8'h38;
   localparam logic [DEC_W-1:0] ADDR_RTR_FORBID = 8'h3C;
   localparam logic [DEC_W-1:0] ADDR_RTR_MEMBER = 8'h40;
   localparam logic [DEC_W-1:0] ADDR_RTR_LIFE   = 8'h44;

   // -------------------------------------------------------------
   // Field positions and reset values
   // -------------------------------------------------------------
   localparam int CTRL_UNK_LSB   = 0;
   localparam int CTRL_V4_IP_BIT = 2;
   localparam int CTRL_V6_IP_BIT = 3;
   localparam int KEY_VALID_BIT  = 31;
   localparam int KEY_STATIC_BIT = 30;
   localparam int KEY_V6_BIT     = 29;
   localparam logic [3:0]        CTRL_RST = 4'h1;
   localparam logic [LIFE_W-1:0] AGE_RST  = 16'h0104;

   // Unknown multicast actions; code 2'b11 acts as drop
   typedef enum logic [1:0] {
      MFL_UNK_DROP   = 2'b00,
      MFL_UNK_FLOOD  = 2'b01,
      MFL_UNK_ROUTER = 2'b10
   } mfl_unk_t;

   // Multicast MAC prefixes for the address-derived key
   localparam logic [24:0] MAC_V4_PFX = 25'h0020_0BC;
   localparam logic [15:0] MAC_V6_PFX = 16'h3333;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam longint CLK_PERIOD_NS = 100;
   localparam longint SECOND_NS     = 1000000000;
   localparam int     SEC_CYCLES    = int'(SECOND_NS / CLK_PERIOD_NS);
   localparam int     HTRANS_ACT    = 1;
endpackage : mfl_pkg

// file: core/mfl_sec_tick.sv
`timescale 1ns/100ps
`default_nettype none
module mfl_sec_tick #(
   parameter int CYCLES = 10
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   output var  logic tick
);
   localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt;

   // Free-running divider, one pulse per period
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt  <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (cnt == LAST);
         cnt  <= (cnt == LAST) ? '0 : cnt + CW'(1);
      end
   end
endmodule : mfl_sec_tick
`default_nettype wire

// file: core/mfl_top.sv
// Functional notes
// [RULE1] Unknown group traffic is dropped, flooded, or sent to router ports only.
// [RULE2] IPv4 key is destination MAC plus VLAN, or destination IP plus VLAN.
// [RULE3] IPv6 uses the same two keys; IP key takes low 32 address bits.
// [RULE4] Group entry keyed by IP version, VLAN and group address; holds members.
// [RULE5] Each group entry has a static versus dynamic type flag.
// [RULE6] Dynamic group entries keep a readable remaining lifetime in seconds.
// [RULE7] Router members per VLAN and version are static union learned ports.
// [RULE8] Forbidden ports never join the learned router members.
// [RULE9] Each router entry has a readable expiry time in seconds.
// [RULE10] Software writes static and forbidden router sets independent of learning.
// [RULE11] Expired dynamic groups and learned router ports are removed; static stay.
`timescale 1ns/100ps
`default_nettype none
module mfl_top
   import mfl_pkg::*;
#(
   parameter int PORTS      = PORTS_DEF,
   parameter int GRP_N      = GRP_N_DEF,
   parameter int RTR_N      = RTR_N_DEF,
   parameter int SEC_CYCLES_P = SEC_CYCLES
) (
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [DATA_W-1:0]   haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [DATA_W-1:0]   hwdata,
   input  wire logic                hready,
   output var  logic                hreadyout,
   output var  logic [DATA_W-1:0]   hrdata,
   output var  logic                hresp,
   input  wire logic                lkp_valid,
   input  wire logic                lkp_ipv6,
   input  wire logic [VID_W-1:0]    lkp_vid,
   input  wire logic [MAC_W-1:0]    lkp_dmac,
   input  wire logic [DIP_W-1:0]    lkp_dip,
   input  wire logic [$clog2(PORTS)-1:0] lkp_src_port,
   output var  logic                res_valid,
   output var  logic                res_known,
   output var  logic [PORTS-1:0]    res_ports,
   input  wire logic                lrn_valid,
   input  wire logic                lrn_router,
   input  wire logic                lrn_ipv6,
   input  wire logic [VID_W-1:0]    lrn_vid,
   input  wire logic [GADDR_W-1:0]  lrn_group,
   input  wire logic [$clog2(PORTS)-1:0] lrn_port
);
   localparam int GIW = (GRP_N > 1) ? $clog2(GRP_N) : 1;
   localparam int RIW = (RTR_N > 1) ? $clog2(RTR_N) : 1;
   localparam logic [PORTS-1:0] ONE = PORTS'(1);

   // -------------------------------------------------------------
   // Bus slave
   // -------------------------------------------------------------
   logic             dp_write;
   logic             rd_wait;
   logic [DEC_W-1:0] dp_addr;
   logic [DATA_W-1:0] rd_word;

   wire acc     = hsel & htrans[HTRANS_ACT] & hready;
   wire word_ok = (hsize == 3'h2) & (haddr[1:0] == 2'h0);

   // Reads take one wait state so a write just before is seen
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         rd_wait  <= 1'b0;
         dp_addr  <= '0;
      end else begin
         dp_write <= acc & hwrite & word_ok;
         rd_wait  <= acc & ~hwrite;
         if (acc) begin
            dp_addr <= haddr[DEC_W-1:0];
         end
      end
   end

   // Read data loaded in the stalled cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (rd_wait) begin
         hrdata <= rd_word;
      end
   end

   assign hreadyout = ~rd_wait;
   assign hresp     = 1'b0;

   wire wr_ctrl   = dp_write & (dp_addr == ADDR_CTRL);
   wire wr_age    = dp_write & (dp_addr == ADDR_AGE);
   wire wr_gsel   = dp_write & (dp_addr == ADDR_GRP_SEL);
   wire wr_gkey   = dp_write & (dp_addr == ADDR_GRP_KEY);
   wire wr_gaddr  = dp_write & (dp_addr == ADDR_GRP_ADDR);
   wire wr_gmem   = dp_write & (dp_addr == ADDR_GRP_MEMBER);
   wire wr_rsel   = dp_write & (dp_addr == ADDR_RTR_SEL);
   wire wr_rkey   = dp_write & (dp_addr == ADDR_RTR_KEY);
   wire wr_rstat  = dp_write & (dp_addr == ADDR_RTR_STATIC);
   wire wr_rforb  = dp_write & (dp_addr == ADDR_RTR_FORBID);

   // -------------------------------------------------------------
   // Global control
   // -------------------------------------------------------------
   logic [1:0]        unk_act;
   logic              v4_ip_key;
   logic              v6_ip_key;
   logic [LIFE_W-1:0] age_time;
   logic [GIW-1:0]    grp_sel;
   logic [RIW-1:0]    rtr_sel;
   logic              age_tick;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {v6_ip_key, v4_ip_key, unk_act} <= CTRL_RST;
         age_time <= AGE_RST;
         grp_sel  <= '0;
         rtr_sel  <= '0;
      end else begin
         if (wr_ctrl) begin
            {v6_ip_key, v4_ip_key, unk_act} <= hwdata[3:0];
         end
         if (wr_age) age_time <= hwdata[LIFE_W-1:0];
         if (wr_gsel) grp_sel <= hwdata[GIW-1:0];
         if (wr_rsel) rtr_sel <= hwdata[RIW-1:0];
      end
   end

   // One-second enable for lifetimes
   mfl_sec_tick #(
      .CYCLES (SEC_CYCLES_P)
   ) u_tick (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (age_tick)
   );

   // -------------------------------------------------------------
   // Group table
   // -------------------------------------------------------------
   logic               g_valid  [GRP_N];
   logic               g_static [GRP_N];
   logic               g_v6     [GRP_N];
   logic [VID_W-1:0]   g_vid    [GRP_N];
   logic [GADDR_W-1:0] g_addr   [GRP_N];
   logic [PORTS-1:0]   g_member [GRP_N];
   logic [LIFE_W-1:0]  g_life   [GRP_N];
   logic [GRP_N-1:0]   g_look;
   logic [GRP_N-1:0]   g_lrn;
   logic               free_ok;
   logic [GIW-1:0]     free_idx;

   wire [PORTS-1:0] lrn_bit  = ONE << lrn_port;
   wire             lrn_grp  = lrn_valid & ~lrn_router;
   wire             lrn_rtr  = lrn_valid & lrn_router;
   wire             lrn_any  = |g_lrn;
   wire             key_ip   = lkp_ipv6 ? v6_ip_key : v4_ip_key; // [RULE2] [RULE3]
   wire [31:0]      lkp_low  = lkp_dip[31:0]; // [RULE3]

   // First free slot for a new dynamic group
   always_comb begin
      free_ok  = 1'b0;
      free_idx = '0;
      for (int k = GRP_N - 1; k >= 0; k--) begin
         if (!g_valid[k]) begin
            free_ok  = 1'b1;
            free_idx = GIW'(k);
         end
      end
   end

   for (genvar gi = 0; gi < GRP_N; gi++) begin : g_ent
      wire [MAC_W-1:0] ent_mac = g_v6[gi] ?
                                 {MAC_V6_PFX, g_addr[gi]} :
                                 {MAC_V4_PFX, g_addr[gi][22:0]};
      wire mine  = (grp_sel == GIW'(gi));
      wire join_e = lrn_grp & (g_lrn[gi] |
                    (~lrn_any & free_ok & (free_idx == GIW'(gi))));
      wire dyn   = g_valid[gi] & ~g_static[gi];
      wire aged  = age_tick & dyn & (g_life[gi] == LIFE_W'(1));

      // Key compare on the selected method
      assign g_look[gi] = g_valid[gi] & (g_v6[gi] == lkp_ipv6) &
                          (g_vid[gi] == lkp_vid) &
                          (key_ip ? (g_addr[gi] == lkp_low) :
                                    (ent_mac == lkp_dmac)); // [RULE4]
      assign g_lrn[gi]  = g_valid[gi] & (g_v6[gi] == lrn_ipv6) &
                          (g_vid[gi] == lrn_vid) &
                          (g_addr[gi] == lrn_group);

      // Age, then software, then learning; learning wins last
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            g_valid[gi]  <= 1'b0;
            g_static[gi] <= 1'b0;
            g_v6[gi]     <= 1'b0;
            g_vid[gi]    <= '0;
            g_addr[gi]   <= '0;
            g_member[gi] <= '0;
            g_life[gi]   <= '0;
         end else begin
            if (age_tick & dyn & (g_life[gi] != '0)) begin
               g_life[gi] <= g_life[gi] - LIFE_W'(1); // [RULE6]
            end
            if (aged) begin
               g_valid[gi]  <= 1'b0; // [RULE11]
               g_member[gi] <= '0;
            end
            if (mine & wr_gkey) begin
               g_valid[gi]  <= hwdata[KEY_VALID_BIT];
               g_static[gi] <= hwdata[KEY_STATIC_BIT]; // [RULE5]
               g_v6[gi]     <= hwdata[KEY_V6_BIT];
               g_vid[gi]    <= hwdata[VID_W-1:0];
               g_life[gi]   <= hwdata[KEY_STATIC_BIT] ? '0 : age_time;
            end
            if (mine & wr_gaddr) g_addr[gi] <= hwdata;
            if (mine & wr_gmem) g_member[gi] <= hwdata[PORTS-1:0];
            if (join_e & g_valid[gi]) begin
               g_member[gi] <= g_member[gi] | lrn_bit;
               if (!g_static[gi]) g_life[gi] <= age_time;
            end else if (join_e) begin
               g_valid[gi]  <= 1'b1;
               g_static[gi] <= 1'b0;
               g_v6[gi]     <= lrn_ipv6;
               g_vid[gi]    <= lrn_vid;
               g_addr[gi]   <= lrn_group;
               g_member[gi] <= lrn_bit;
               g_life[gi]   <= age_time;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Router table
   // -------------------------------------------------------------
   logic             r_valid  [RTR_N];
   logic             r_v6     [RTR_N];
   logic [VID_W-1:0] r_vid    [RTR_N];
   logic [PORTS-1:0] r_static [RTR_N];
   logic [PORTS-1:0] r_forbid [RTR_N];
   logic [PORTS-1:0] r_learn  [RTR_N];
   logic [PORTS-1:0] r_member [RTR_N];
   logic [LIFE_W-1:0] r_life  [RTR_N];
   logic [RTR_N-1:0] r_look;

   for (genvar ri = 0; ri < RTR_N; ri++) begin : r_ent
      wire mine   = (rtr_sel == RIW'(ri));
      wire hit    = lrn_rtr & r_valid[ri] & (r_v6[ri] == lrn_ipv6) &
                    (r_vid[ri] == lrn_vid);
      wire aged   = age_tick & ~hit & (r_life[ri] == LIFE_W'(1));
      wire [PORTS-1:0] forb_eff = (mine & wr_rforb) ?
                                  hwdata[PORTS-1:0] : r_forbid[ri];
      wire [PORTS-1:0] keep = aged ? '0 : r_learn[ri]; // [RULE11]
      wire [PORTS-1:0] add  = hit ? lrn_bit : '0;
      wire [PORTS-1:0] next_learn = (keep | add) & ~forb_eff; // [RULE8]

      assign r_member[ri] = r_static[ri] | r_learn[ri]; // [RULE7]
      assign r_look[ri]   = r_valid[ri] & (r_v6[ri] == lkp_ipv6) &
                            (r_vid[ri] == lkp_vid);

      // Software sets stay apart from the learned set
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            r_valid[ri]  <= 1'b0;
            r_v6[ri]     <= 1'b0;
            r_vid[ri]    <= '0;
            r_static[ri] <= '0;
            r_forbid[ri] <= '0;
            r_learn[ri]  <= '0;
            r_life[ri]   <= '0;
         end else begin
            if (mine & wr_rkey) begin
               r_valid[ri] <= hwdata[KEY_VALID_BIT];
               r_v6[ri]    <= hwdata[KEY_V6_BIT];
               r_vid[ri]   <= hwdata[VID_W-1:0];
            end
            if (mine & wr_rstat) r_static[ri] <= hwdata[PORTS-1:0]; // [RULE10]
            r_forbid[ri] <= forb_eff; // [RULE10]
            r_learn[ri]  <= next_learn;
            if (hit) begin
               r_life[ri] <= age_time; // [RULE9]
            end else if (age_tick & (r_life[ri] != '0)) begin
               r_life[ri] <= r_life[ri] - LIFE_W'(1);
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Forwarding decision
   // -------------------------------------------------------------
   logic [PORTS-1:0] grp_ports;
   logic [PORTS-1:0] rtr_ports;
   logic [PORTS-1:0] next_ports;

   wire [PORTS-1:0] src_bit = ONE << lkp_src_port;
   wire             known   = |g_look;

   // Union of every matching group entry; separate union of every matching router entry
   always_comb begin
      grp_ports = '0;
      rtr_ports = '0;
      for (int k = 0; k < GRP_N; k++) begin
         if (g_look[k]) grp_ports = grp_ports | g_member[k];
      end
      for (int k = 0; k < RTR_N; k++) begin
         if (r_look[k]) rtr_ports = rtr_ports | r_member[k];
      end
   end

   // Unknown groups follow the configured action
   always_comb begin
      if (known) begin
         next_ports = grp_ports;
      end else begin
         case (unk_act)
            MFL_UNK_FLOOD:  next_ports = '1; // [RULE1]
            MFL_UNK_ROUTER: next_ports = rtr_ports; // [RULE1]
            default:        next_ports = '0; // [RULE1]
         endcase
      end
   end

   // Ingress port never gets its own frame back
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         res_valid <= 1'b0;
         res_known <= 1'b0;
         res_ports <= '0;
      end else begin
         res_valid <= lkp_valid;
         res_known <= lkp_valid & known;
         res_ports <= lkp_valid ? (next_ports & ~src_bit) : '0;
      end
   end

   // -------------------------------------------------------------
   // Read selection
   // -------------------------------------------------------------
   wire [DATA_W-1:0] rd_ctrl = DATA_W'({v6_ip_key, v4_ip_key, unk_act});
   wire [DATA_W-1:0] rd_gkey = {g_valid[grp_sel], g_static[grp_sel],
                                g_v6[grp_sel], 17'h0, g_vid[grp_sel]};
   wire [DATA_W-1:0] rd_rkey = {r_valid[rtr_sel], 1'b0, r_v6[rtr_sel],
                                17'h0, r_vid[rtr_sel]};

   assign rd_word =
      (dp_addr == ADDR_CTRL)       ? rd_ctrl :
      (dp_addr == ADDR_AGE)        ? DATA_W'(age_time) :
      (dp_addr == ADDR_GRP_SEL)    ? DATA_W'(grp_sel) :
      (dp_addr == ADDR_GRP_KEY)    ? rd_gkey :
      (dp_addr == ADDR_GRP_ADDR)   ? g_addr[grp_sel] :
      (dp_addr == ADDR_GRP_MEMBER) ? DATA_W'(g_member[grp_sel]) :
      (dp_addr == ADDR_GRP_LIFE)   ? DATA_W'(g_life[grp_sel]) : // [RULE6]
      (dp_addr == ADDR_RTR_SEL)    ? DATA_W'(rtr_sel) :
      (dp_addr == ADDR_RTR_KEY)    ? rd_rkey :
      (dp_addr == ADDR_RTR_STATIC) ? DATA_W'(r_static[rtr_sel]) :
      (dp_addr == ADDR_RTR_FORBID) ? DATA_W'(r_forbid[rtr_sel]) :
      (dp_addr == ADDR_RTR_MEMBER) ? DATA_W'(r_member[rtr_sel]) :
      (dp_addr == ADDR_RTR_LIFE)   ? DATA_W'(r_life[rtr_sel]) : // [RULE9]
      '0;
endmodule : mfl_top
`default_nettype wire

// file: tb/mfl_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module mfl_top_asserts
   import mfl_pkg::*;
#(
   parameter int PORTS        = PORTS_DEF,
   parameter int SEC_CYCLES_P = SEC_CYCLES
) (
   input wire logic                     hclk,
   input wire logic                     hresetn,
   input wire logic                     hsel,
   input wire logic [DATA_W-1:0]        haddr,
   input wire logic [1:0]               htrans,
   input wire logic                     hwrite,
   input wire logic [2:0]               hsize,
   input wire logic [DATA_W-1:0]        hwdata,
   input wire logic                     hready,
   input wire logic                     hreadyout,
   input wire logic                     hresp,
   input wire logic                     lkp_valid,
   input wire logic [$clog2(PORTS)-1:0] lkp_src_port,
   input wire logic                     res_valid,
   input wire logic                     res_known,
   input wire logic [PORTS-1:0]         res_ports
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Shadow of the unknown action
   logic       wr_ctrl;
   logic [1:0] act;
   wire        rd_req = hsel & htrans[1] & ~hwrite & hready;
   wire        wr_req = hsel & htrans[1] & hwrite & hready;
   wire        unk    = res_valid & ~res_known;

   // Moves with the design's copy
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ctrl <= 1'b0;
         act     <= CTRL_RST[1:0];
      end else begin
         if (hready) wr_ctrl <= wr_req & (hsize == 3'h2) &
                                (haddr[7:0] == ADDR_CTRL);
         if (wr_ctrl & hready) act <= hwdata[1:0];
      end
   end

   sequence s_rd_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_read_stall;
      rd_req |=> s_rd_answer;
   endproperty
   property p_write_nowait;
      wr_req |=> hreadyout;
   endproperty
   property p_hresp_okay;
      hresp == 1'b0;
   endproperty
   property p_res_follows;
      1'b1 |=> (res_valid == $past(lkp_valid));
   endproperty
   property p_idle_ports;
      !res_valid |-> (res_ports == '0);
   endproperty
   property p_src_cleared;
      res_valid |-> !res_ports[$past(lkp_src_port)];
   endproperty
   property p_drop_unknown;
      unk && ($past(act[0]) == $past(act[1])) |-> (res_ports == '0);
   endproperty
   property p_flood_unknown;
      unk && ($past(act) == 2'b01) |->
         (res_ports == ({PORTS{1'b1}} ^ (PORTS'(1) << $past(lkp_src_port))));
   endproperty

   a_read_stall: assert property (p_read_stall)
      else $error("bad read stall");
   a_write_nowait: assert property (p_write_nowait)
      else $error("write stalled");
   a_hresp_okay: assert property (p_hresp_okay)
      else $error("bad response");
   a_res_follows: assert property (p_res_follows)
      else $error("result strobe late");
   a_idle_ports: assert property (p_idle_ports)
      else $error("idle port mask set");
   a_src_cleared: assert property (p_src_cleared)
      else $error("ingress port in result");
   a_drop_unknown: assert property (p_drop_unknown)
      else $error("unknown not dropped");
   a_flood_unknown: assert property (p_flood_unknown)
      else $error("unknown not flooded");
endmodule : mfl_top_asserts

bind mfl_top mfl_top_asserts #(.PORTS(PORTS), .SEC_CYCLES_P(SEC_CYCLES_P))
   mfl_top_asserts_inst (.*);
`default_nettype wire

// file: tb/mfl_port_model.sv
`timescale 1ns/100ps
`default_nettype none
module mfl_port_model
   import mfl_pkg::*;
#(
   parameter int PORTS = PORTS_DEF
) (
   input  wire logic                     hclk,
   input  wire logic                     res_valid,
   input  wire logic                     res_known,
   input  wire logic [PORTS-1:0]         res_ports,
   output var  logic                     lkp_valid,
   output var  logic                     lkp_ipv6,
   output var  logic [VID_W-1:0]         lkp_vid,
   output var  logic [MAC_W-1:0]         lkp_dmac,
   output var  logic [DIP_W-1:0]         lkp_dip,
   output var  logic [$clog2(PORTS)-1:0] lkp_src_port,
   output var  logic                     lrn_valid,
   output var  logic                     lrn_router,
   output var  logic                     lrn_ipv6,
   output var  logic [VID_W-1:0]         lrn_vid,
   output var  logic [GADDR_W-1:0]       lrn_group,
   output var  logic [$clog2(PORTS)-1:0] lrn_port
);
   // Idle ingress and snooping sides at time zero
   initial begin
      {lkp_valid, lkp_ipv6, lkp_vid, lkp_dmac, lkp_dip, lkp_src_port} = '0;
      {lrn_valid, lrn_router, lrn_ipv6, lrn_vid, lrn_group, lrn_port} = '0;
   end

   // One lookup pulse, then MAC and IP lines inverted
   task lookup(input logic v6, input logic [VID_W-1:0] vid,
               input logic [MAC_W-1:0] mac, input logic [31:0] ip,
               input logic [$clog2(PORTS)-1:0] src, output logic [31:0] r);
      @(posedge hclk);
      lkp_valid    <= 1'b1;
      lkp_ipv6     <= v6;
      lkp_vid      <= vid;
      lkp_dmac     <= mac;
      lkp_dip      <= {32'hFF0E0000, 64'h0, ip};
      lkp_src_port <= src;
      @(posedge hclk);
      lkp_valid <= 1'b0;
      lkp_dmac  <= ~mac;
      lkp_dip   <= ~lkp_dip;
      @(negedge hclk);
      r = {res_valid, res_known, 30'(res_ports)};
   endtask : lookup

   // One learn event
   task learn(input logic rtr, input logic v6, input logic [VID_W-1:0] vid,
              input logic [31:0] grp, input logic [$clog2(PORTS)-1:0] p);
      @(posedge hclk);
      lrn_valid  <= 1'b1;
      lrn_router <= rtr;
      lrn_ipv6   <= v6;
      lrn_vid    <= vid;
      lrn_group  <= grp;
      lrn_port   <= p;
      @(posedge hclk);
      lrn_valid <= 1'b0;
      lrn_group <= ~grp;
   endtask : learn
endmodule : mfl_port_model
`default_nettype wire

// file: tb/mfl_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module mfl_top_tb
   import mfl_pkg::*;
;
   logic hclk = 1'b0, hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire hready, hresp, res_valid, res_known, lkp_valid, lkp_ipv6, lrn_valid;
   wire lrn_router, lrn_ipv6;
   wire [31:0] hrdata, lrn_group;
   wire [9:0] res_ports;
   wire [11:0] lkp_vid, lrn_vid;
   wire [47:0] lkp_dmac;
   wire [127:0] lkp_dip;
   wire [3:0] lkp_src_port, lrn_port;
   int error_cnt = 0, checked = 0;
   logic [9:0] unk_exp [4] = '{10'h000, 10'h3FE, 10'h042, 10'h000};

   // 10 MHz clock
   always #50 hclk = ~hclk;

   mfl_top #(.SEC_CYCLES_P(8)) mfl_top_inst (.*, .hreadyout(hready));
   mfl_port_model #(.PORTS(10)) mfl_port_model_inst (.*);

   // ---------------------------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------------------------
   task check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Ready sampled mid-cycle, where it has settled
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic r;
      @(posedge hclk);
      {hsel, htrans, hwrite, hsize} <= {1'b1, 2'b10, w, 3'h2};
      haddr <= {24'h0, a};
      do begin @(negedge hclk); r = hready; @(posedge hclk); end
      while (r !== 1'b1);
      {hsel, htrans} <= 3'b000;
      if (w) hwdata <= d;
      do begin @(negedge hclk); r = hready; q = hrdata; @(posedge hclk); end
      while (r !== 1'b1);
   endtask : ahb

   task wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask : wr

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      check(q, exp);
   endtask : rdc

   // Lifetime 40 less up to two ticks before the read
   task rdl(input logic [7:0] a);
      ahb(1'b0, a, 32'h0);
      check(32'(q > 32'd37 && q < 32'd41), 32'h1);
   endtask : rdl

   task lk(input logic v6, input logic [11:0] vid, input logic [47:0] mac,
           input logic [31:0] ip, input logic [3:0] src, input logic k,
           input logic [9:0] p);
      logic [31:0] r;
      mfl_port_model_inst.lookup(v6, vid, mac, ip, src, r);
      check(r, {1'b1, k, 30'(p)});
   endtask : lk

   task complete_run;
      $display("Checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(ADDR_CTRL, 32'h1);
      rdc(ADDR_AGE, 32'h104);
      wr(8'h7C, 32'hFFFF);
      rdc(8'h7C, 32'h0);
      wr(ADDR_AGE, 32'd40);
      wr(ADDR_RTR_SEL, 32'h0);
      wr(ADDR_RTR_KEY, 32'h8000_0005);
      wr(ADDR_RTR_STATIC, 32'h003);
      wr(ADDR_RTR_FORBID, 32'h010);
      mfl_port_model_inst.learn(1'b1, 1'b0, 12'd5, 32'h0, 4'd4);
      mfl_port_model_inst.learn(1'b1, 1'b0, 12'd5, 32'h0, 4'd6);
      rdc(ADDR_RTR_MEMBER, 32'h043);
      rdl(ADDR_RTR_LIFE);
      rdc(ADDR_RTR_FORBID, 32'h010);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_CTRL, i);
         lk(0, 12'd5, 48'h01005E7F0001, 32'h0, 4'd0, 0, unk_exp[i]);
      end
      // Static IPv4 group, reached by both key methods
      wr(ADDR_GRP_SEL, 32'h0);
      wr(ADDR_GRP_KEY, 32'hC000_0005);
      wr(ADDR_GRP_ADDR, 32'hE000_0102);
      wr(ADDR_GRP_MEMBER, 32'h0F0);
      wr(ADDR_CTRL, 32'h1);
      lk(0, 12'd5, 48'h01005E000102, 32'h0, 4'd4, 1, 10'h0E0);
      lk(0, 12'd6, 48'h01005E000102, 32'h0, 4'd4, 0, 10'h3EF);
      wr(ADDR_CTRL, 32'h5);
      lk(0, 12'd5, 48'h0, 32'hE000_0102, 4'd4, 1, 10'h0E0);
      rdc(ADDR_GRP_KEY, 32'hC000_0005);
      // Dynamic IPv6 group
      wr(ADDR_GRP_SEL, 32'h1);
      wr(ADDR_GRP_KEY, 32'hA000_0007);
      wr(ADDR_GRP_ADDR, 32'h1234_5678);
      wr(ADDR_GRP_MEMBER, 32'h300);
      rdl(ADDR_GRP_LIFE);
      lk(1, 12'd7, 48'h0, 32'h1234_5678, 4'd0, 0, 10'h3FE);
      lk(1, 12'd7, 48'h333312345678, 32'h0, 4'd0, 1, 10'h300);
      wr(ADDR_CTRL, 32'hD);
      lk(1, 12'd7, 48'h0, 32'h1234_5678, 4'd0, 1, 10'h300);
      mfl_port_model_inst.learn(1'b0, 1'b0, 12'd5, 32'hE000_0909, 4'd2);
      lk(0, 12'd5, 48'h0, 32'hE000_0909, 4'd0, 1, 10'h004);
      // Over 40 ticks: dynamic state gone
      repeat (400) @(posedge hclk);
      lk(0, 12'd5, 48'h0, 32'hE000_0909, 4'd0, 0, 10'h3FE);
      rdc(ADDR_GRP_KEY, 32'h2000_0007);
      wr(ADDR_GRP_SEL, 32'h0);
      rdc(ADDR_GRP_KEY, 32'hC000_0005);
      rdc(ADDR_RTR_MEMBER, 32'h003);
      complete_run();
   end

   // Watchdog, about seven times the run
   initial begin
      repeat (4000) @(posedge hclk);
      error_cnt++;
      complete_run();
   end
endmodule : mfl_top_tb
`default_nettype wire
